// ### rtl/trcw_pkg.sv
// constants, types and register map for the channel reconfiguration writer
package trcw_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int WORD_W = 16; // one image word as sent to the channel
  localparam int ADDR_W = 6; // index into the stored image
  localparam int DEPTH = 64; // image words held
  localparam int SEL_W = 2; // channel select width
  localparam int NUM_CH = 4; // channels in the transceiver block
  localparam int IRQ_W = 2; // interrupt status width

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00; // mode, power-down, channel select
  localparam logic [7:0] OFS_CMD = 8'h04; // write trigger, write only
  localparam logic [7:0] OFS_STAT = 8'h08; // busy, done, word index
  localparam logic [7:0] OFS_ISTAT = 8'h0C; // sticky events, cleared by read
  localparam logic [7:0] OFS_IMASK = 8'h10; // interrupt mask
  localparam logic [7:0] OFS_IPTR = 8'h14; // image load pointer
  localparam logic [7:0] OFS_IDAT = 8'h18; // image load data, pointer steps
  localparam logic [7:0] OFS_LEN = 8'h1C; // words in the image

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_CONT = 0; // continuous write mode
  localparam int CTRL_PD = 1; // block power-down request
  localparam int CTRL_SEL = 4; // lsb of channel select
  localparam int CMD_GO = 0; // write trigger
  localparam int STAT_BUSY = 0; // operation running
  localparam int STAT_DONE = 1; // reconfiguration complete
  localparam int STAT_PD = 2; // block powered down
  localparam int STAT_IDX = 8; // lsb of next word index
  localparam int IRQ_DONE = 0; // completion event
  localparam int IRQ_WORD = 1; // one word accepted by the channel

  // ----------------------------------------------------------------
  // bus answers and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_NS = 50; // 20 MHz
  localparam int PD_MIN_NS = 1000; // least power-down pulse, 1 us
  localparam int PD_MIN_CYC = (PD_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int PD_CNT_W = 5;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SEND = 4'h2,
    ST_HOLD = 4'h4,
    ST_DONE = 4'h8
  } trcw_state_t;

  typedef struct packed {
    logic [SEL_W-1:0] sel; // target channel
    logic [ADDR_W-1:0] addr; // word position within the image
    logic [WORD_W-1:0] data; // image word
  } trcw_word_t;

endpackage : trcw_pkg

// ### rtl/trcw_writer.sv
// channel reconfiguration writer with axi4-lite registers and block power-down

module trcw_writer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [31:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic blk_pwrdn_in,
  output logic [trcw_pkg::NUM_CH-1:0] chan_pwrdn,
  output logic ch_wr_valid,
  output trcw_pkg::trcw_word_t ch_word,
  input wire logic ch_wr_ready,
  output logic busy,
  output logic reconfig_done,
  output logic irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-lane merge of a bus write onto an old value
  function automatic logic [31:0] trcw_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : trcw_merge

  // is the byte offset one of ours
  function automatic logic trcw_hit(input logic [31:0] a);
    logic [7:0] o;
    o = a[7:0];
    return (a[31:8] == '0) && (o == trcw_pkg::OFS_CTRL || o == trcw_pkg::OFS_CMD ||
           o == trcw_pkg::OFS_STAT || o == trcw_pkg::OFS_ISTAT || o == trcw_pkg::OFS_IMASK ||
           o == trcw_pkg::OFS_IPTR || o == trcw_pkg::OFS_IDAT || o == trcw_pkg::OFS_LEN);
  endfunction : trcw_hit

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [trcw_pkg::WORD_W-1:0] img_mem [trcw_pkg::DEPTH]; // stored image
  logic [31:0] ctrl_q; // control register
  logic [trcw_pkg::ADDR_W-1:0] iptr_q; // load pointer
  logic [trcw_pkg::ADDR_W:0] len_q; // image length, wide enough for full depth
  logic [trcw_pkg::IRQ_W-1:0] istat_q; // sticky events
  logic [trcw_pkg::IRQ_W-1:0] imask_q; // enables
  trcw_pkg::trcw_state_t st_q; // writer state
  logic [trcw_pkg::ADDR_W:0] idx_q; // next word to send
  logic run_cont_q; // mode latched at start
  logic [trcw_pkg::SEL_W-1:0] run_sel_q; // channel latched at start
  logic pd_meta_q, pd_sync_q; // pin synchroniser
  logic [trcw_pkg::PD_CNT_W-1:0] pd_cnt_q; // power-down stretch
  logic have_aw_q, have_w_q; // write halves already taken
  logic [31:0] aw_addr_q, w_data_q;
  logic [3:0] w_strb_q;

  // ----------------------------------------------------------------
  // write channel decode
  // ----------------------------------------------------------------
  wire aw_hs = s_awvalid & s_awready;
  wire w_hs = s_wvalid & s_wready;
  wire aw_now = have_aw_q | aw_hs;
  wire w_now = have_w_q | w_hs;
  wire wr_do = aw_now & w_now & ~s_bvalid; // both halves present
  wire [31:0] wr_addr = have_aw_q ? aw_addr_q : s_awaddr;
  wire [31:0] wr_data = have_w_q ? w_data_q : s_wdata;
  wire [3:0] wr_strb = have_w_q ? w_strb_q : s_wstrb;
  wire wr_hit = wr_do & trcw_hit(wr_addr);
  wire [7:0] wr_ofs = wr_addr[7:0];
  wire have_aw_d = aw_now & ~wr_do;
  wire have_w_d = w_now & ~wr_do;
  wire bvalid_d = wr_do | (s_bvalid & ~s_bready);
  wire [31:0] wr_ctrl = trcw_merge(ctrl_q, wr_data, wr_strb);
  wire go = wr_hit & (wr_ofs == trcw_pkg::OFS_CMD) & wr_strb[0] & wr_data[trcw_pkg::CMD_GO];
  wire running = (st_q == trcw_pkg::ST_SEND) | (st_q == trcw_pkg::ST_HOLD);
  // image loads are refused while running so the outgoing word stays stable
  wire img_wr = wr_hit & (wr_ofs == trcw_pkg::OFS_IDAT) & ~running;

  // ----------------------------------------------------------------
  // read channel decode
  // ----------------------------------------------------------------
  wire rd_do = s_arvalid & s_arready;
  wire rvalid_d = rd_do | (s_rvalid & ~s_rready);
  wire [7:0] rd_ofs = s_araddr[7:0];
  wire rd_hit = trcw_hit(s_araddr);
  wire rd_istat = rd_do & rd_hit & (rd_ofs == trcw_pkg::OFS_ISTAT);
  wire [31:0] stat_val = {17'h0, idx_q, 5'h0, chan_pwrdn[0], reconfig_done, busy};
  wire [31:0] rd_val =
      (rd_ofs == trcw_pkg::OFS_CTRL) ? ctrl_q :
      (rd_ofs == trcw_pkg::OFS_STAT) ? stat_val :
      (rd_ofs == trcw_pkg::OFS_ISTAT) ? {30'h0, istat_q} :
      (rd_ofs == trcw_pkg::OFS_IMASK) ? {30'h0, imask_q} :
      (rd_ofs == trcw_pkg::OFS_IPTR) ? {26'h0, iptr_q} :
      (rd_ofs == trcw_pkg::OFS_LEN) ? {25'h0, len_q} : 32'h0;

  // ----------------------------------------------------------------
  // power-down path
  // ----------------------------------------------------------------
  wire pd_req = ctrl_q[trcw_pkg::CTRL_PD] | pd_sync_q;
  wire pd_act = pd_req | (pd_cnt_q != '0);

  // ----------------------------------------------------------------
  // writer decode
  // ----------------------------------------------------------------
  wire take = ch_wr_valid & ch_wr_ready; // channel accepted a word
  wire last = (idx_q + 7'h01) >= len_q; // the word being taken is the last
  wire start = go & ~pd_act & ~running; // new operation from idle or done
  wire resume = go & ~pd_act & (st_q == trcw_pkg::ST_HOLD); // next single word
  wire [trcw_pkg::ADDR_W:0] idx_n = take ? idx_q + 7'h01 : (start ? '0 : idx_q);
  wire [trcw_pkg::SEL_W-1:0] sel_n =
      start ? ctrl_q[trcw_pkg::CTRL_SEL +: trcw_pkg::SEL_W] : run_sel_q;
  wire [trcw_pkg::IRQ_W-1:0] ev = {take, take & last};
  wire [trcw_pkg::IRQ_W-1:0] istat_d = (istat_q & ~{trcw_pkg::IRQ_W{rd_istat}}) | ev;

  // ----------------------------------------------------------------
  // bus handshake registers
  // ----------------------------------------------------------------
  // ready is dropped once a half is held, so a second address cannot overwrite it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= trcw_pkg::RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      have_aw_q <= have_aw_d;
      have_w_q <= have_w_d;
      s_awready <= ~have_aw_d & ~bvalid_d;
      s_wready <= ~have_w_d & ~bvalid_d;
      s_bvalid <= bvalid_d;
      if (aw_hs) begin
        aw_addr_q <= s_awaddr;
      end
      if (w_hs) begin
        w_data_q <= s_wdata;
        w_strb_q <= s_wstrb;
      end
      if (wr_do) begin
        s_bresp <= trcw_hit(wr_addr) ? trcw_pkg::RESP_OKAY : trcw_pkg::RESP_SLVERR;
      end
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= trcw_pkg::RESP_OKAY;
    end else begin
      s_arready <= ~rvalid_d;
      s_rvalid <= rvalid_d;
      if (rd_do) begin
        s_rdata <= rd_hit ? rd_val : 32'h0;
        s_rresp <= rd_hit ? trcw_pkg::RESP_OKAY : trcw_pkg::RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // status read clears, but an event in the same cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
      imask_q <= '0;
      iptr_q <= '0;
      len_q <= '0;
      istat_q <= '0;
      irq <= 1'b0;
    end else begin
      istat_q <= istat_d;
      irq <= |(istat_d & imask_q);
      if (wr_hit && wr_ofs == trcw_pkg::OFS_CTRL) begin
        ctrl_q <= wr_ctrl;
      end
      if (wr_hit && wr_ofs == trcw_pkg::OFS_IMASK) begin
        imask_q <= trcw_pkg::IRQ_W'(trcw_merge({30'h0, imask_q}, wr_data, wr_strb));
      end
      if (wr_hit && wr_ofs == trcw_pkg::OFS_LEN && !running) begin
        len_q <= wr_data[trcw_pkg::ADDR_W:0]; // low seven bits taken, not limited to the image depth
      end
      if (wr_hit && wr_ofs == trcw_pkg::OFS_IPTR) begin
        iptr_q <= wr_data[trcw_pkg::ADDR_W-1:0];
      end else if (img_wr) begin
        iptr_q <= iptr_q + 6'h01; // streaming load
      end
    end
  end

  // image store, loaded by software word by word
  always_ff @(posedge aclk) begin
    if (img_wr) begin
      img_mem[iptr_q] <= wr_data[trcw_pkg::WORD_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // block power-down
  // ----------------------------------------------------------------
  // pin is asynchronous; stretch keeps any request on for the least pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_meta_q <= 1'b0;
      pd_sync_q <= 1'b0;
      pd_cnt_q <= '0;
      chan_pwrdn <= '0;
    end else begin
      pd_meta_q <= blk_pwrdn_in;
      pd_sync_q <= pd_meta_q;
      if (pd_req) begin
        pd_cnt_q <= trcw_pkg::PD_CNT_W'(trcw_pkg::PD_MIN_CYC);
      end else if (pd_cnt_q != '0) begin
        pd_cnt_q <= pd_cnt_q - 5'h01;
      end
      chan_pwrdn <= {trcw_pkg::NUM_CH{pd_act}};
    end
  end

  // ----------------------------------------------------------------
  // writer state machine
  // ----------------------------------------------------------------
  // power-down aborts any operation and silences the channel port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= trcw_pkg::ST_IDLE;
      idx_q <= '0;
      run_cont_q <= 1'b0;
      run_sel_q <= '0;
      ch_wr_valid <= 1'b0;
      ch_word <= '0;
      busy <= 1'b0;
      reconfig_done <= 1'b0;
    end else begin
      idx_q <= idx_n;
      run_sel_q <= sel_n;
      // only the latched channel is addressed; write-only port
      ch_word <= {sel_n, idx_n[trcw_pkg::ADDR_W-1:0],
                  img_mem[idx_n[trcw_pkg::ADDR_W-1:0]]};
      if (pd_act) begin
        st_q <= trcw_pkg::ST_IDLE;
        ch_wr_valid <= 1'b0;
        busy <= 1'b0;
        reconfig_done <= 1'b0;
      end else begin
        case (st_q)
          trcw_pkg::ST_IDLE, trcw_pkg::ST_DONE: begin
            if (start) begin
              run_cont_q <= ctrl_q[trcw_pkg::CTRL_CONT];
              reconfig_done <= (len_q == '0);
              busy <= (len_q != '0);
              ch_wr_valid <= (len_q != '0);
              st_q <= (len_q == '0) ? trcw_pkg::ST_DONE : trcw_pkg::ST_SEND;
            end
          end
          trcw_pkg::ST_SEND: begin
            if (take && last) begin
              ch_wr_valid <= 1'b0;
              busy <= 1'b0;
              reconfig_done <= 1'b1;
              st_q <= trcw_pkg::ST_DONE;
            end else if (take && !run_cont_q) begin
              ch_wr_valid <= 1'b0;
              st_q <= trcw_pkg::ST_HOLD;
            end
            // continuous mode keeps valid up for the next word
          end
          trcw_pkg::ST_HOLD: begin
            if (resume) begin
              ch_wr_valid <= 1'b1;
              st_q <= trcw_pkg::ST_SEND;
            end
          end
          default: begin
            st_q <= trcw_pkg::ST_IDLE;
            ch_wr_valid <= 1'b0;
            busy <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  pd_all_chan_a: assert property (pd_req |=> (&chan_pwrdn) && !busy && !ch_wr_valid)
    else $error("power-down did not reach every channel");
  chan_scope_a: assert property (ch_wr_valid |-> ch_word.sel == run_sel_q)
    else $error("word addressed to a channel other than the selected one");
  write_only_a: assert property (ch_wr_valid |-> busy && st_q == trcw_pkg::ST_SEND)
    else $error("channel transfer outside a write operation");
  cont_stream_a: assert property (take && run_cont_q && !last && !pd_act |=>
    ch_wr_valid ##0 ch_word.addr == $past(ch_word.addr) + 6'h01)
    else $error("continuous mode stopped between words");
  word_hold_a: assert property (ch_wr_valid && !ch_wr_ready && !pd_act |=>
    ch_wr_valid && $stable(ch_word))
    else $error("offered word changed before it was taken");
  busy_span_a: assert property (start && len_q != '0 |=> busy ##1
    (busy || reconfig_done || chan_pwrdn[0]))
    else $error("busy not raised by the trigger");
  done_mark_a: assert property (take && last && !pd_act |=> reconfig_done && !busy)
    else $error("completion not flagged after last word");
  one_word_a: assert property (take && !run_cont_q && !last && !pd_act |=>
    !ch_wr_valid ##1 (!ch_wr_valid || $past(resume)))
    else $error("regular mode sent more than one word per trigger");

  cont_run_c: cover property (start && ctrl_q[trcw_pkg::CTRL_CONT] ##[1:200] reconfig_done);
  single_run_c: cover property (st_q == trcw_pkg::ST_HOLD ##[1:50] resume);
  pd_abort_c: cover property (busy ##1 pd_act);

endmodule : trcw_writer

// ### verification/trcw_chan_model.sv
// channel-side partner: takes reconfiguration words, prompt, stalling or stuck
module trcw_chan_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ch_wr_valid,
  input wire trcw_pkg::trcw_word_t ch_word,
  input wire logic [1:0] stall_mode,
  input wire logic busy,
  input wire logic reconfig_done,
  output logic ch_wr_ready,
  output logic tx_rst,
  output logic cdr_rst
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] rnd_q = 16'hACE1; // private stall pattern, apart from the bench sequence
  logic unused_w; // valid and word are only observed by the bench
  logic [2:0] gap_q; // cycles since completion was seen

  assign unused_w = ch_wr_valid ^ (^ch_word);

  // ----------------------------------------------------------------
  // ready: 0 prompt, 1 random stalls, 2 held low to force an abort
  // ----------------------------------------------------------------
  // the port has no read path, a channel only ever sinks words
  // each accepted item is one 16-bit image word with its position
  always @(posedge aclk) begin
    rnd_q <= {rnd_q[14:0], rnd_q[15] ^ rnd_q[13] ^ rnd_q[12] ^ rnd_q[10]};
    if (!aresetn) begin
      ch_wr_ready <= 1'b0;
    end else begin
      ch_wr_ready <= (stall_mode == 2'h0) | ((stall_mode == 2'h1) & rnd_q[0]);
    end
  end

  // user reset sequencing: both resets held over a run, tx released at
  // completion, receiver clock recovery only five cycles later
  always @(posedge aclk) begin
    if (!aresetn || busy) begin
      tx_rst <= 1'b1;
      cdr_rst <= 1'b1;
      gap_q <= 3'h0;
    end else if (reconfig_done) begin
      tx_rst <= 1'b0;
      if (gap_q != 3'h5) begin
        gap_q <= gap_q + 3'h1;
      end
      cdr_rst <= tx_rst | (gap_q != 3'h5);
    end
  end
endmodule : trcw_chan_model

// ### verification/tb_top.sv
// self-checking bench for the channel reconfiguration writer
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic aclk = 1'b0, aresetn = 1'b0, blk_pwrdn_in = 1'b0;
  logic [31:0] s_awaddr = 32'h0, s_wdata = 32'h0, s_araddr = 32'h0, s_rdata;
  logic [3:0] s_wstrb = 4'hF, chan_pwrdn;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ch_wr_valid, ch_wr_ready;
  logic [1:0] s_bresp, s_rresp, stall_mode = 2'h0;
  logic busy, reconfig_done, irq, tx_rst, cdr_rst;
  trcw_pkg::trcw_word_t ch_word;
  trcw_pkg::trcw_word_t got_q[$]; // words seen crossing the channel port
  logic [15:0] img[64]; // expected image
  logic [31:0] seed = 32'ha9745e65, d;
  logic [1:0] r, sel;
  int fails = 0, n_checks = 0, cyc = 0, len;

  always #25 aclk = ~aclk; // 20 MHz

  trcw_writer i_trcw_writer (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .blk_pwrdn_in(blk_pwrdn_in), .chan_pwrdn(chan_pwrdn), .ch_wr_valid(ch_wr_valid),
    .ch_word(ch_word), .ch_wr_ready(ch_wr_ready), .busy(busy),
    .reconfig_done(reconfig_done), .irq(irq));

  trcw_chan_model i_trcw_chan_model (.aclk(aclk), .aresetn(aresetn),
    .ch_wr_valid(ch_wr_valid), .ch_word(ch_word), .stall_mode(stall_mode),
    .busy(busy), .reconfig_done(reconfig_done), .ch_wr_ready(ch_wr_ready),
    .tx_rst(tx_rst), .cdr_rst(cdr_rst));

  // ----------------------------------------------------------------
  // helpers: random source, comparison, closing report
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // hang guard, generous against the well under a thousand cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      complete_run();
    end
  end

  // collect every word the channel accepts
  always @(posedge aclk) begin
    if (ch_wr_valid === 1'b1 && ch_wr_ready === 1'b1) begin
      got_q.push_back(ch_word);
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite master: hold each channel until its own ready is seen
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_ok, w_ok;
    int n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    n = 0;
    @(posedge aclk);
    s_awaddr <= {24'h0, a};
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw_ok && w_ok) && n < 200) begin
      @(posedge aclk);
      n++;
      if (!aw_ok && s_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w_ok && s_wready === 1'b1) begin
        w_ok = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_bvalid !== 1'b1 && ++n < 200);
    resp = s_bresp;
    s_bready <= 1'b0;
    chk(n < 200, "write hung");
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_araddr <= {24'h0, a};
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge aclk); while (s_arready !== 1'b1 && ++n < 200);
    s_arvalid <= 1'b0;
    do @(posedge aclk); while (s_rvalid !== 1'b1 && ++n < 200);
    v = s_rdata;
    resp = s_rresp;
    s_rready <= 1'b0;
    chk(n < 200, "read hung");
  endtask : rd

  // random image of n words, loaded through the pointer and data registers
  task automatic load(input int n);
    wr(trcw_pkg::OFS_IPTR, 32'h0, r);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      img[i] = seed[15:0];
      wr(trcw_pkg::OFS_IDAT, {16'h0, img[i]}, r);
    end
    wr(trcw_pkg::OFS_LEN, n, r);
    got_q.delete();
  endtask : load

  task automatic wait_done;
    int n;
    n = 0;
    do @(posedge aclk); while (reconfig_done !== 1'b1 && ++n < 2000);
    chk(n < 2000, "no completion");
  endtask : wait_done

  // words in order, on the chosen channel, image unchanged
  task automatic check_words(input int n);
    chk(got_q.size() == n, "word count");
    for (int i = 0; i < got_q.size() && i < n; i++) begin
      chk(got_q[i].data === img[i] && got_q[i].addr === i[5:0], "word");
      chk(got_q[i].sel === sel, "wrong channel");
    end
  endtask : check_words

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(trcw_pkg::OFS_STAT, d, r);
    chk(d === 32'h0 && busy === 1'b0, "status after reset");
    rd(8'h40, d, r);
    chk(r === trcw_pkg::RESP_SLVERR && d === 32'h0, "unmapped read");
    wr(8'h44, 32'h1, r);
    chk(r === trcw_pkg::RESP_SLVERR, "unmapped write");
    $display("test reset done");
    // continuous runs: full depth, single word, random length, stalling channel
    foreach (img[t]) begin
      if (t > 2) break;
      seed = lfsr(seed);
      len = (t == 0) ? 64 : (t == 1) ? 1 : 2 + seed[3:0];
      sel = seed[5:4];
      stall_mode <= 2'h1;
      load(len);
      wr(trcw_pkg::OFS_CTRL, {26'h0, sel, 4'h1}, r);
      rd(trcw_pkg::OFS_ISTAT, d, r);
      wr(trcw_pkg::OFS_IMASK, 32'h1, r);
      wr(trcw_pkg::OFS_CMD, 32'h1, r);
      if (len > 8) chk(busy === 1'b1, "busy not raised");
      wait_done();
      check_words(len);
      repeat (2) @(posedge aclk);
      chk(irq === 1'b1 && busy === 1'b0, "done irq");
      chk(tx_rst === 1'b0 && cdr_rst === 1'b1, "reset order");
      rd(trcw_pkg::OFS_ISTAT, d, r);
      chk(d[1:0] === 2'h3, "istat events");
      repeat (2) @(posedge aclk);
      chk(irq === 1'b0, "irq not cleared");
      chk(cdr_rst === 1'b0, "cdr reset not released");
      $display("test continuous len %0d done", len);
    end
    // regular mode: one word per trigger, interrupt masked
    sel = seed[7:6];
    load(5);
    wr(trcw_pkg::OFS_CTRL, {26'h0, sel, 4'h0}, r);
    wr(trcw_pkg::OFS_IMASK, 32'h0, r);
    for (int i = 0; i < 5; i++) begin
      wr(trcw_pkg::OFS_CMD, 32'h1, r);
      for (int k = 0; k < 100 && got_q.size() <= i; k++) @(posedge aclk);
      repeat (6) @(posedge aclk);
      chk(got_q.size() == i + 1, "one word per trigger");
      if (i < 4) chk(busy === 1'b1 && reconfig_done === 1'b0, "busy between words");
    end
    check_words(5);
    chk(reconfig_done === 1'b1 && busy === 1'b0 && irq === 1'b0, "regular end");
    rd(trcw_pkg::OFS_ISTAT, d, r);
    chk(d[1:0] === 2'h3, "regular events");
    rd(trcw_pkg::OFS_STAT, d, r);
    chk(d === ((32'h5 << trcw_pkg::STAT_IDX) | (32'h1 << trcw_pkg::STAT_DONE)), "status");
    $display("test regular done");
    // power-down by register: trigger refused, hold after release
    wr(trcw_pkg::OFS_CTRL, 32'h2, r);
    repeat (2) @(posedge aclk);
    chk(chan_pwrdn === 4'hF, "register power-down");
    got_q.delete();
    wr(trcw_pkg::OFS_CMD, 32'h1, r);
    repeat (4) @(posedge aclk);
    chk(busy === 1'b0 && got_q.size() == 0, "trigger while down");
    wr(trcw_pkg::OFS_CTRL, 32'h0, r);
    repeat (trcw_pkg::PD_MIN_CYC - 4) @(posedge aclk);
    chk(chan_pwrdn === 4'hF, "power-down hold");
    repeat (12) @(posedge aclk);
    chk(chan_pwrdn === 4'h0, "power-up");
    // pin power-down aborts a stuck run; pulse kept at the least width
    stall_mode <= 2'h2;
    wr(trcw_pkg::OFS_CTRL, 32'h1, r);
    wr(trcw_pkg::OFS_CMD, 32'h1, r);
    repeat (4) @(posedge aclk);
    chk(busy === 1'b1, "stuck run busy");
    blk_pwrdn_in <= 1'b1;
    repeat (trcw_pkg::PD_MIN_CYC + 2) @(posedge aclk);
    chk(chan_pwrdn === 4'hF && busy === 1'b0 && reconfig_done === 1'b0, "abort");
    blk_pwrdn_in <= 1'b0;
    repeat (40) @(posedge aclk);
    chk(chan_pwrdn === 4'h0, "pin power-up");
    $display("test power-down done");
    complete_run();
  end
endmodule : tb_top
